// [pkg/lfp_consts.svh]
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit axi4-lite slave with word-aligned registers
`ifndef LFP_CONSTS_SVH
`define LFP_CONSTS_SVH

`define LFP_ADDR_W 8
`define LFP_OFF_CFG 8'h00
`define LFP_OFF_CHEN 8'h04
`define LFP_OFF_FLAGS 8'h08
`define LFP_OFF_MASK 8'h0C
`define LFP_OFF_CHFLT 8'h10
`define LFP_OFF_STATE 8'h14

`define LFP_CFG_DEN 0
`define LFP_CFG_LINE_SWITCH_ENABLE 1
`define LFP_CFG_ADAPTIVE_LOOP_ENABLE 2
`define LFP_CFG_OPEN_AUTO_DISCONNECT_EN 3
`define LFP_CFG_SHORT_AUTO_DISCONNECT_EN 4
`define LFP_CFG_RST 32'h0000_0002

`define LFP_FLG_INPUT_OVERVOLTAGE_FLAG 0
`define LFP_FLG_INPUT_OVERCURRENT_FLAG 1
`define LFP_FLG_THERMAL_SHUTDOWN_FLAG 2
`define LFP_FLG_EARLY_OVERTEMP_FLAG 3
`define LFP_FLG_OUTPUT_OVERVOLTAGE_FLAG 4
`define LFP_FLG_LED_FAULT_FLAG 5
`define LFP_NFLAGS 6

`define LFP_CHEN_RST 4'hF
`define LFP_MASK_RST 6'h00
`define LFP_RESP_OKAY 2'b00
`define LFP_RESP_SLVERR 2'b10

// channels must be on more than this many main clocks before detection runs
`define LFP_CH_SETTLE 32
`define LFP_SS_TIME_NS 1000
`define LFP_CLK_NS 10
`define LFP_SS_CYCLES (`LFP_SS_TIME_NS / `LFP_CLK_NS)

`endif

// [pkg/lfp_pkg.sv]
// types for the led driver fault supervisor
// used by rtl/lfp_top.sv together with lfp_consts.svh
package lfp_pkg;
	typedef enum logic [2:0] {
		LFP_SHUTDOWN,
		LFP_STANDBY,
		LFP_SOFTSTART,
		LFP_RUN,
		LFP_RECOVERY,
		LFP_THERMAL
	} lfp_state_t;
endpackage

// [rtl/lfp_top.sv]
// fault supervision, recovery and register file of a 4-channel led driver
// assumes synchronous comparator inputs and an axi4-lite master on clk
`timescale 1ns/10ps
`default_nettype none
`include "lfp_consts.svh"

module lfp_top #(
	parameter int NCH = 4,
	parameter int FRAME_CYCLES = 1000
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic en_pin_above_th1,
	input wire logic uvlo_ok,
	input wire logic vin_ovp_det,
	input wire logic vin_ovp_clear,
	input wire logic ocp_det,
	input wire logic thermal_det,
	input wire logic thermal_clear,
	input wire logic early_alert_det,
	input wire logic feedback_input_ovp,
	input wire logic dac_at_reference,
	input wire logic [NCH-1:0] open_cmp,
	input wire logic [NCH-1:0] short_cmp,
	output logic line_switch_gate_drive,
	output logic converter_on,
	output logic [NCH-1:0] channel_on,
	output logic adaptive_up,
	output logic fault_out,
	input wire logic [`LFP_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`LFP_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import lfp_pkg::*;

	localparam logic [15:0] FRAME_W = 16'(FRAME_CYCLES);
	localparam logic [7:0] SS_W = 8'(`LFP_SS_CYCLES);

	lfp_state_t state_reg;
	logic [7:0] cfg_reg;
	logic [NCH-1:0] chen_reg;
	logic [`LFP_NFLAGS-1:0] flags_reg;
	logic [`LFP_NFLAGS-1:0] mask_reg;
	logic [NCH-1:0] open_flag_reg;
	logic [NCH-1:0] short_flag_reg;
	logic [7:0] ss_cnt_reg;
	logic [15:0] frame_cnt_reg;
	logic [5:0] on_cnt_reg;
	logic [NCH-1:0] open_pend_reg;
	logic [`LFP_ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic aw_have_reg;
	logic w_have_reg;
	logic cfg_strb_reg;

	logic bus_alive;
	logic lsw_en;
	logic in_ovp;
	logic in_ocp;
	logic critical;
	logic detect_en;
	logic wr_fire;
	logic clr_flags;
	logic clr_chflt;
	logic [`LFP_NFLAGS-1:0] ev;
	logic [NCH-1:0] open_conf;
	logic [NCH-1:0] short_hit;
	logic [NCH-1:0] chen_drop;

	// bus and device are dead without supply or main enable
	assign bus_alive = en_pin_above_th1 && uvlo_ok;
	assign lsw_en = cfg_reg[`LFP_CFG_LINE_SWITCH_ENABLE];
	// without a line switch nothing can act on input faults
	assign in_ovp = lsw_en && vin_ovp_det;
	assign in_ocp = lsw_en && ocp_det;
	assign critical = in_ovp || in_ocp;
	assign detect_en = (state_reg == LFP_RUN) &&
		(on_cnt_reg > 6'(`LFP_CH_SETTLE));
	assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign clr_flags = wr_fire && awaddr_reg == `LFP_OFF_FLAGS;
	assign clr_chflt = wr_fire && awaddr_reg == `LFP_OFF_CHFLT;

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			// open waits for the dac to hit reference before confirming
			assign open_conf[gi] = detect_en && open_pend_reg[gi] &&
				open_cmp[gi] && dac_at_reference;
			assign short_hit[gi] = detect_en && short_cmp[gi];
			assign chen_drop[gi] = cfg_reg[`LFP_CFG_ADAPTIVE_LOOP_ENABLE] &&
				((open_conf[gi] && cfg_reg[`LFP_CFG_OPEN_AUTO_DISCONNECT_EN]) ||
				(short_hit[gi] && cfg_reg[`LFP_CFG_SHORT_AUTO_DISCONNECT_EN]));
		end
	endgenerate

	always_comb begin
		ev = '0;
		ev[`LFP_FLG_INPUT_OVERVOLTAGE_FLAG] = in_ovp;
		ev[`LFP_FLG_INPUT_OVERCURRENT_FLAG] = in_ocp;
		ev[`LFP_FLG_THERMAL_SHUTDOWN_FLAG] = thermal_det;
		ev[`LFP_FLG_EARLY_OVERTEMP_FLAG] = early_alert_det;
		ev[`LFP_FLG_OUTPUT_OVERVOLTAGE_FLAG] = feedback_input_ovp;
		ev[`LFP_FLG_LED_FAULT_FLAG] = |open_conf || |short_hit;
	end

	// supervisor sequence
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= LFP_SHUTDOWN;
		end else if (!bus_alive) begin
			state_reg <= LFP_SHUTDOWN;
		end else begin
			case (state_reg)
				LFP_SHUTDOWN: state_reg <= LFP_STANDBY;
				LFP_STANDBY: begin
					if (cfg_reg[`LFP_CFG_DEN])
						state_reg <= LFP_SOFTSTART;
				end
				LFP_SOFTSTART, LFP_RUN: begin
					if (!cfg_reg[`LFP_CFG_DEN])
						state_reg <= LFP_STANDBY;
					else if (critical)
						state_reg <= LFP_RECOVERY;
					else if (thermal_det)
						state_reg <= LFP_THERMAL;
					else if (state_reg == LFP_SOFTSTART && ss_cnt_reg == SS_W)
						state_reg <= LFP_RUN;
				end
				LFP_RECOVERY: begin
					if (!cfg_reg[`LFP_CFG_DEN])
						state_reg <= LFP_STANDBY;
					else if (!critical && (!vin_ovp_det || vin_ovp_clear))
						state_reg <= LFP_SOFTSTART;
				end
				LFP_THERMAL: begin
					if (!cfg_reg[`LFP_CFG_DEN])
						state_reg <= LFP_STANDBY;
					else if (thermal_clear)
						state_reg <= LFP_SOFTSTART;
				end
				default: state_reg <= LFP_SHUTDOWN;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ss_cnt_reg <= 8'h00;
		end else if (state_reg != LFP_SOFTSTART) begin
			ss_cnt_reg <= 8'h00;
		end else if (ss_cnt_reg != SS_W) begin
			ss_cnt_reg <= ss_cnt_reg + 8'h01;
		end
	end

	// channels outlast the converter by one frame in thermal shutdown
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			frame_cnt_reg <= 16'h0000;
		end else if (state_reg != LFP_THERMAL) begin
			frame_cnt_reg <= 16'h0000;
		end else if (frame_cnt_reg != FRAME_W) begin
			frame_cnt_reg <= frame_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			on_cnt_reg <= 6'h00;
		end else if (state_reg != LFP_RUN || ~|channel_on) begin
			on_cnt_reg <= 6'h00;
		end else if (!on_cnt_reg[5] || on_cnt_reg == 6'(`LFP_CH_SETTLE)) begin
			on_cnt_reg <= on_cnt_reg + 6'h01;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			open_pend_reg <= '0;
			adaptive_up <= 1'b0;
		end else begin
			open_pend_reg <= detect_en ? (open_cmp & chen_reg) : '0;
			// raise the output while an open hit is unconfirmed
			adaptive_up <= detect_en && |(open_cmp & chen_reg) &&
				!dac_at_reference;
		end
	end

	// outputs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			line_switch_gate_drive <= 1'b0;
			converter_on <= 1'b0;
			channel_on <= '0;
		end else begin
			// off in standby, recovery and on any critical fault
			line_switch_gate_drive <= lsw_en && !critical && bus_alive &&
				(state_reg == LFP_SOFTSTART || state_reg == LFP_RUN ||
				state_reg == LFP_THERMAL);
			converter_on <= bus_alive && !critical && !thermal_det &&
				!feedback_input_ovp &&
				(state_reg == LFP_SOFTSTART || state_reg == LFP_RUN);
			if (!bus_alive || state_reg == LFP_STANDBY ||
				state_reg == LFP_SHUTDOWN || state_reg == LFP_RECOVERY ||
				(state_reg == LFP_THERMAL && frame_cnt_reg == FRAME_W))
				channel_on <= '0;
			else if (state_reg == LFP_RUN)
				channel_on <= chen_reg & ~chen_drop;
			else if (state_reg == LFP_SOFTSTART)
				channel_on <= '0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			fault_out <= 1'b0;
		else
			fault_out <= |(flags_reg & ~mask_reg);
	end

	// sticky flags; hardware set wins over a software clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flags_reg <= '0;
			open_flag_reg <= '0;
			short_flag_reg <= '0;
		end else if (!bus_alive) begin
			flags_reg <= '0;
			open_flag_reg <= '0;
			short_flag_reg <= '0;
		end else begin
			flags_reg <= (flags_reg &
				~(clr_flags ? wdata_reg[`LFP_NFLAGS-1:0] : '0)) | ev;
			open_flag_reg <= (open_flag_reg &
				~(clr_chflt ? wdata_reg[NCH-1:0] : '0)) | open_conf;
			short_flag_reg <= (short_flag_reg &
				~(clr_chflt ? wdata_reg[NCH+7:8] : '0)) | short_hit;
		end
	end

	// configuration; volatile contents are lost only at shutdown
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_reg <= 8'(`LFP_CFG_RST);
			chen_reg <= NCH'(`LFP_CHEN_RST);
			mask_reg <= `LFP_MASK_RST;
		end else if (!bus_alive) begin
			cfg_reg <= 8'(`LFP_CFG_RST);
			chen_reg <= NCH'(`LFP_CHEN_RST);
			mask_reg <= `LFP_MASK_RST;
		end else begin
			if (wr_fire && awaddr_reg == `LFP_OFF_CFG && cfg_strb_reg)
				cfg_reg <= wdata_reg[7:0];
			if (wr_fire && awaddr_reg == `LFP_OFF_MASK)
				mask_reg <= wdata_reg[`LFP_NFLAGS-1:0];
			if (wr_fire && awaddr_reg == `LFP_OFF_CHEN)
				chen_reg <= wdata_reg[NCH-1:0] & ~chen_drop;
			else
				chen_reg <= chen_reg & ~chen_drop;
		end
	end

	// axi4-lite write path: address and data taken in either order
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LFP_RESP_OKAY;
			cfg_strb_reg <= 1'b0;
		end else begin
			s_axi_awready <= bus_alive && !aw_have_reg && !s_axi_awready;
			s_axi_wready <= bus_alive && !w_have_reg && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				// strobe is only valid beside wvalid, so keep it with the data
				cfg_strb_reg <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_reg <= `LFP_OFF_CHFLT &&
					awaddr_reg[1:0] == 2'b00) ?
					`LFP_RESP_OKAY : `LFP_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// axi4-lite read path
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `LFP_RESP_OKAY;
		end else begin
			s_axi_arready <= bus_alive && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `LFP_RESP_OKAY;
				case (s_axi_araddr)
					`LFP_OFF_CFG: s_axi_rdata <= {24'h00_0000, cfg_reg};
					`LFP_OFF_CHEN: s_axi_rdata <= 32'(chen_reg);
					`LFP_OFF_FLAGS: s_axi_rdata <= 32'(flags_reg);
					`LFP_OFF_MASK: s_axi_rdata <= 32'(mask_reg);
					`LFP_OFF_CHFLT: s_axi_rdata <= 32'(open_flag_reg) |
						(32'(short_flag_reg) << 8);
					`LFP_OFF_STATE: s_axi_rdata <= 32'(state_reg);
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `LFP_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// [dv/lfp_checker.sv]
// port assertions for the led driver fault supervisor
// assumes a single clk domain with async active-low resetn
`timescale 1ns/10ps
`default_nettype none
module lfp_checker #(
	parameter int NCH = 4
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic en_pin_above_th1,
	input wire logic uvlo_ok,
	input wire logic vin_ovp_det,
	input wire logic ocp_det,
	input wire logic thermal_det,
	input wire logic feedback_input_ovp,
	input wire logic line_switch_gate_drive,
	input wire logic converter_on,
	input wire logic [NCH-1:0] channel_on,
	input wire logic fault_out,
	input wire logic s_axi_awready,
	input wire logic s_axi_arready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	AST_EN_OFF: assert property (!en_pin_above_th1 |=>
		!line_switch_gate_drive && !converter_on && channel_on == '0)
		else $error("outputs active after enable pin low");
	AST_UVLO: assert property (!uvlo_ok |=>
		!s_axi_awready && !s_axi_arready && !converter_on)
		else $error("bus or converter alive in lockout");
	AST_THERM: assert property (thermal_det |=> !converter_on)
		else $error("converter on during thermal fault");
	AST_OUTPUT_OVERVOLTAGE_FLAG: assert property (feedback_input_ovp |=> !converter_on)
		else $error("converter on after output overvoltage");
	AST_INPUT_OVERVOLTAGE_FLAG: assert property (
		vin_ovp_det && line_switch_gate_drive |=> !line_switch_gate_drive)
		else $error("line switch kept on in input overvoltage");
	AST_OCP: assert property (
		ocp_det && line_switch_gate_drive |=> !line_switch_gate_drive)
		else $error("line switch kept on in overcurrent");
	AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before accepted");
	AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before accepted");
	cover property (vin_ovp_det && line_switch_gate_drive);
	cover property (thermal_det && converter_on);
	cover property (fault_out && s_axi_rvalid);
endmodule
bind lfp_top lfp_checker #(.NCH(NCH)) u_chk (.*);
`default_nettype wire

// [dv/lfp_partner.sv]
// far side: led strings and the adaptive output dac
// assumes the bench names which strings are broken
`timescale 1ns/10ps
`default_nettype none
module lfp_partner #(
	parameter int NCH = 4,
	parameter int RISE = 6
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [NCH-1:0] channel_on,
	input wire logic adaptive_up,
	input wire logic [NCH-1:0] open_fail,
	input wire logic [NCH-1:0] short_fail,
	output logic [NCH-1:0] open_cmp,
	output logic [NCH-1:0] short_cmp,
	output logic dac_at_reference
);
	int rise_cnt;
	// a broken string only shows while its sinker conducts
	assign open_cmp = open_fail & channel_on;
	assign short_cmp = short_fail & channel_on;
	// output falls back to target once every open string recovers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rise_cnt <= 0;
		end else if (open_fail == '0) begin
			rise_cnt <= 0;
		end else if (adaptive_up && rise_cnt < RISE) begin
			rise_cnt <= rise_cnt + 1;
		end
	end
	assign dac_at_reference = (rise_cnt == RISE);
endmodule
`default_nettype wire

// [dv/tb_led_driver_fault_protection.sv]
// self-checking bench for the fault supervisor
// assumes lfp_top, lfp_partner and the bound checker
`timescale 1ns/10ps
`default_nettype none
`include "lfp_consts.svh"
module tb_led_driver_fault_protection;
	import lfp_pkg::*;
	localparam int FRM = 20;
	localparam logic [31:0] RUNCFG = 32'h0000_0007;
	logic clk, resetn, en_pin_above_th1, uvlo_ok, vin_ovp_det, vin_ovp_clear;
	logic ocp_det, thermal_det, thermal_clear, early_alert_det;
	logic feedback_input_ovp, dac_at_reference, line_switch_gate_drive;
	logic converter_on, adaptive_up, fault_out;
	logic [3:0] open_cmp, short_cmp, channel_on, open_fail, short_fail;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	int fails, cmp_count;
	lfp_top #(.FRAME_CYCLES(FRM)) dut (.*);
	lfp_partner #(.NCH(4)) far (.*);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// ready is registered, so its level at the negedge is what the edge sees
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		tb = 1'h0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!tb) begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			rr = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
		end
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		tr = 1'h0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!tr) begin
			@(negedge clk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			rv = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'h0;
		end
		s_axi_rready <= 1'h0;
	endtask
	task automatic wait_st(input lfp_state_t s);
		int n;
		n = 0;
		rv = 32'hFFFF_FFFF;
		while (rv !== 32'(s) && n < 300) begin
			rd(`LFP_OFF_STATE);
			n++;
		end
		chk(rv, 32'(s));
	endtask
	task automatic t_regs;
		rd(`LFP_OFF_CFG);
		chk(rv, `LFP_CFG_RST);
		rd(`LFP_OFF_CHEN);
		chk(rv, 32'h0000_000F);
		rd(8'h40);
		chk(32'(rr), 32'(`LFP_RESP_SLVERR));
		chk(32'(line_switch_gate_drive), 32'h0);
		wr(`LFP_OFF_CFG, RUNCFG);
		wait_st(LFP_RUN);
		chk(32'(line_switch_gate_drive), 32'h1);
		$display("regs test done");
	endtask
	task automatic t_ovp;
		vin_ovp_det <= 1'h1;
		repeat (3) @(posedge clk);
		chk(32'(line_switch_gate_drive), 32'h0);
		rd(`LFP_OFF_FLAGS);
		chk(rv & 32'h1, 32'h1);
		chk(32'(fault_out), 32'h1);
		rd(`LFP_OFF_STATE);
		chk(rv, 32'(LFP_RECOVERY));
		// outlast one soft-start so a retry would have shown
		repeat (150) @(posedge clk);
		chk(32'(line_switch_gate_drive), 32'h0);
		vin_ovp_det <= 1'h0;
		vin_ovp_clear <= 1'h1;
		wait_st(LFP_RUN);
		wr(`LFP_OFF_FLAGS, 32'h0000_003F);
		repeat (3) @(posedge clk);
		chk(32'(fault_out), 32'h0);
		$display("ovp test done");
	endtask
	task automatic t_ocp;
		wr(`LFP_OFF_MASK, 32'h0000_0002);
		ocp_det <= 1'h1;
		repeat (3) @(posedge clk);
		chk(32'(line_switch_gate_drive), 32'h0);
		rd(`LFP_OFF_FLAGS);
		chk(rv & 32'h2, 32'h2);
		chk(32'(fault_out), 32'h0);
		wr(`LFP_OFF_CFG, 32'h0000_0006);
		wait_st(LFP_STANDBY);
		rd(`LFP_OFF_MASK);
		chk(rv, 32'h0000_0002);
		ocp_det <= 1'h0;
		wr(`LFP_OFF_FLAGS, 32'h0000_003F);
		wr(`LFP_OFF_CFG, RUNCFG);
		wait_st(LFP_RUN);
		$display("ocp test done");
	endtask
	task automatic t_therm;
		early_alert_det <= 1'h1;
		@(posedge clk);
		early_alert_det <= 1'h0;
		rd(`LFP_OFF_FLAGS);
		chk(rv & 32'h8, 32'h8);
		rd(`LFP_OFF_STATE);
		chk(rv, 32'(LFP_RUN));
		thermal_det <= 1'h1;
		repeat (2) @(posedge clk);
		chk(32'(converter_on), 32'h0);
		chk(32'(channel_on), 32'h0000_000F);
		repeat (FRM + 4) @(posedge clk);
		chk(32'(channel_on), 32'h0);
		thermal_det <= 1'h0;
		thermal_clear <= 1'h1;
		wait_st(LFP_RUN);
		thermal_clear <= 1'h0;
		rd(`LFP_OFF_FLAGS);
		chk(rv & 32'h4, 32'h4);
		wr(`LFP_OFF_FLAGS, 32'h0000_003F);
		$display("thermal test done");
	endtask
	task automatic t_chan;
		wr(`LFP_OFF_CFG, 32'h0000_0017);
		short_fail <= 4'h2;
		// detection only starts once the channels have settled
		repeat (40) @(posedge clk);
		rd(`LFP_OFF_CHFLT);
		chk(rv & 32'h0000_0F0F, 32'h0000_0200);
		rd(`LFP_OFF_CHEN);
		chk(rv, 32'h0000_000D);
		short_fail <= 4'h0;
		wr(`LFP_OFF_CFG, RUNCFG);
		// brief open vanishes before the dac tops out
		open_fail <= 4'h8;
		repeat (2) @(posedge clk);
		open_fail <= 4'h4;
		repeat (30) @(posedge clk);
		open_fail <= 4'h0;
		rd(`LFP_OFF_CHFLT);
		chk(rv & 32'h0000_000F, 32'h0000_0004);
		rd(`LFP_OFF_FLAGS);
		chk(rv & 32'h20, 32'h20);
		rd(`LFP_OFF_CHEN);
		chk(rv, 32'h0000_000D);
		wr(`LFP_OFF_CFG, 32'h0000_000F);
		open_fail <= 4'h1;
		repeat (30) @(posedge clk);
		open_fail <= 4'h0;
		rd(`LFP_OFF_CHEN);
		chk(rv, 32'h0000_000C);
		$display("channel test done");
	endtask
	task automatic t_off;
		wr(`LFP_OFF_CFG, 32'h0000_0005);
		vin_ovp_det <= 1'h1;
		repeat (3) @(posedge clk);
		rd(`LFP_OFF_STATE);
		chk(rv, 32'(LFP_RUN));
		vin_ovp_det <= 1'h0;
		feedback_input_ovp <= 1'h1;
		@(posedge clk);
		feedback_input_ovp <= 1'h0;
		rd(`LFP_OFF_FLAGS);
		chk(rv & 32'h10, 32'h10);
		chk(rv & 32'h1, 32'h0);
		en_pin_above_th1 <= 1'h0;
		repeat (2) @(posedge clk);
		chk(32'({line_switch_gate_drive, converter_on}), 32'h0);
		en_pin_above_th1 <= 1'h1;
		rd(`LFP_OFF_CFG);
		chk(rv, `LFP_CFG_RST);
		wr(`LFP_OFF_CFG, RUNCFG);
		wait_st(LFP_RUN);
		chk(32'(converter_on), 32'h1);
		uvlo_ok <= 1'h0;
		repeat (3) @(posedge clk);
		chk(32'(converter_on), 32'h0);
		uvlo_ok <= 1'h1;
		rd(`LFP_OFF_CFG);
		chk(rv, `LFP_CFG_RST);
		$display("shutdown test done");
	endtask
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		{vin_ovp_det, vin_ovp_clear, ocp_det, thermal_det} = 4'h0;
		{thermal_clear, early_alert_det, feedback_input_ovp} = 3'h0;
		{open_fail, short_fail, s_axi_awaddr, s_axi_araddr} = 24'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		en_pin_above_th1 = 1'h1;
		uvlo_ok = 1'h1;
		fails = 0;
		cmp_count = 0;
		resetn = 1'h0;
		repeat (2) @(posedge clk);
		resetn <= 1'h1;
		repeat (2) @(posedge clk);
		t_regs;
		t_ovp;
		t_ocp;
		t_therm;
		t_chan;
		t_off;
		stop_test;
	end
	// all tests take about a thousand clocks
	initial begin
		#300000;
		fails++;
		stop_test;
	end
endmodule
`default_nettype wire
